/* File: rtl/eac_top.v */
// Control logic behind the rear external analog control connector.
// Assumes an APB master on clk_sys, panel keys written by firmware, and
// protection flags and the regulation mode from logic on clk_sys.
// What this block does
// - Ignore external inputs unless master setting active
// - Interlock mode, pair open: output off, indicator
// - Interlock mode, pair shorted: button controls output
// - Direct mode: pair shorted on, open off
// - Shut-off edge polarity follows shut-off setting
// - Valid shut-off edge: output off, latch indicator
// - Recovery needs idle pin then escape key
// - Only edges shut off, never steady levels
// - Regulation status high in CV, low CC
// - Control pin high or open local, low analog
// - Analog control shows one fewer decimal digit
// - Control-source status high local, low analog
// - Power-good high normally, low on fault
// - Fault summary covers all eight conditions
// - Analog, voltage source: setpoint from program voltage
// - Analog, resistance source: setpoint from resistor
// - Range setting picks 10 or 5 full scale
`timescale 1ns/10ps
`default_nettype none
`include "eac_regs.vh"

module eac_top (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Connector inputs
  input  wire        enable_shorted,
  input  wire        shutoff_pin,
  input  wire        control_source_pin,
  // Supply state from clk_sys logic
  input  wire        cv_regulating,
  input  wire        fault_ovp,
  input  wire        fault_ocp,
  input  wire        fault_otp,
  input  wire        fault_ac_line,
  input  wire        fault_remote,
  // Connector outputs
  output reg         regulation_mode_status,
  output reg         control_source_status,
  output reg         power_good,
  // Supply and display controls
  output reg         output_on,
  output reg         enable_inhibit_indicator,
  output reg         shutoff_indicator,
  output reg         fewer_digits,
  output reg         setpoint_from_volt,
  output reg         setpoint_from_res,
  output reg         program_range_5v
);

  // ========================================================================
  // Reset release
  reg        rst_meta_r;
  reg        rst_n;

  // Assert at once, release after two edges
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ========================================================================
  // Address decode
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `EAC_OFF_CTRL) || (a == `EAC_OFF_KEY) || (a == `EAC_OFF_STATUS);
    end
  endfunction

  wire       apb_setup  = psel & ~penable;
  wire       apb_access = psel & penable;
  wire       apb_write  = apb_access & pwrite & addr_ok(paddr);

  // Zero wait states; unmapped address answers with an error
  assign pready  = 1'b1;
  assign pslverr = apb_access & ~addr_ok(paddr);

  // ========================================================================
  // Control register and key pulses
  reg [`EAC_CTRL_W-1:0] ctrl_r;
  reg                   key_onoff_r;
  reg                   key_esc_r;

  // Writes land at the access edge; keys last one cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r      <= `EAC_CTRL_RST;
      key_onoff_r <= 1'b0;
      key_esc_r   <= 1'b0;
    end else begin
      key_onoff_r <= apb_write & (paddr == `EAC_OFF_KEY) & pwdata[`EAC_KEY_ONOFF];
      key_esc_r   <= apb_write & (paddr == `EAC_OFF_KEY) & pwdata[`EAC_KEY_ESC];
      if (apb_write && paddr == `EAC_OFF_CTRL) begin
        ctrl_r <= pwdata[`EAC_CTRL_W-1:0];
      end
    end
  end

  wire ext_active  = ctrl_r[`EAC_CTRL_EXT];
  wire direct_mode = ctrl_r[`EAC_CTRL_DIRECT];
  wire rise_trig   = ctrl_r[`EAC_CTRL_RISE];

  // ========================================================================
  // Pin synchronisers and edge detection
  wire [2:0] pin_s;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;

  eac_sync #(.W(3)) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   ({control_source_pin, shutoff_pin, enable_shorted}),
    .pin_sync (pin_s)
  );

  eac_edge #(.W(3)) u_edge (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .level   (pin_s),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  wire en_s      = pin_s[0];
  wire so_s      = pin_s[1];
  wire local_s   = pin_s[2];

  // Only a transition of the pin counts, steady levels never do
  wire so_edge   = ext_active & (rise_trig ? pin_rise[1] : pin_fall[1]);
  wire so_idle   = rise_trig ? ~so_s : so_s;

  // ========================================================================
  // Shut-off latch and enable-inhibit indicator
  reg  so_latch_r;
  reg  inhibit_r;
  wire interlock = ext_active & ~direct_mode;

  // New edge wins over an escape in the same cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      so_latch_r <= 1'b0;
    end else if (so_edge) begin
      so_latch_r <= 1'b1;
    end else if (key_esc_r && so_idle) begin
      so_latch_r <= 1'b0;
    end else if (!ext_active) begin
      so_latch_r <= 1'b0;
    end
  end

  // Inhibit shown while pair open; escape clears it once shorted
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inhibit_r <= 1'b0;
    end else if (interlock && !en_s) begin
      inhibit_r <= 1'b1;
    end else if (!interlock) begin
      inhibit_r <= 1'b0;
    end else if (key_esc_r) begin
      inhibit_r <= 1'b0;
    end
  end

  // ========================================================================
  // Panel output state
  reg  panel_on_r;
  wire button_ok = ~ext_active | (interlock & en_s & ~inhibit_r & ~so_latch_r);

  // Button toggles when allowed; forced off by open pair, shut-off or direct mode
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      panel_on_r <= 1'b0;
    end else if (so_edge || (interlock && !en_s)) begin
      panel_on_r <= 1'b0;
    end else if (ext_active && direct_mode) begin
      panel_on_r <= 1'b0;
    end else if (key_onoff_r && button_ok) begin
      panel_on_r <= ~panel_on_r;
    end
  end

  // Effective output per enable mode
  reg out_nxt;
  always @* begin
    if (!ext_active) begin
      out_nxt = panel_on_r;
    end else if (direct_mode) begin
      out_nxt = en_s & ~so_latch_r & ~so_edge;
    end else begin
      out_nxt = panel_on_r & en_s & ~so_latch_r & ~so_edge;
    end
  end

  // ========================================================================
  // Control source and fault summary
  wire analog    = ext_active & ~local_s;
  wire fault_any = fault_ovp | fault_ocp | fault_otp | fault_ac_line
                 | inhibit_r | so_latch_r | fault_remote | ~out_nxt;

  // Registered connector and display outputs
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      output_on                <= 1'b0;
      enable_inhibit_indicator <= 1'b0;
      shutoff_indicator        <= 1'b0;
      regulation_mode_status   <= 1'b0;
      control_source_status    <= 1'b1;
      power_good               <= 1'b0;
      fewer_digits             <= 1'b0;
      setpoint_from_volt       <= 1'b0;
      setpoint_from_res        <= 1'b0;
      program_range_5v         <= 1'b0;
    end else begin
      output_on                <= out_nxt;
      enable_inhibit_indicator <= inhibit_r;
      shutoff_indicator        <= so_latch_r;
      regulation_mode_status   <= cv_regulating;
      control_source_status    <= ~analog;
      power_good               <= ~fault_any;
      fewer_digits             <= analog;
      setpoint_from_volt       <= analog & ~ctrl_r[`EAC_CTRL_RES];
      setpoint_from_res        <= analog & ctrl_r[`EAC_CTRL_RES];
      program_range_5v         <= ctrl_r[`EAC_CTRL_5V];
    end
  end

  // ========================================================================
  // Read data, captured in the setup cycle
  wire [`EAC_ST_W-1:0] status_w;

  assign status_w[`EAC_ST_OUT_ON]  = output_on;
  assign status_w[`EAC_ST_INHIBIT] = enable_inhibit_indicator;
  assign status_w[`EAC_ST_SHUTOFF] = shutoff_indicator;
  assign status_w[`EAC_ST_ANALOG]  = ~control_source_status;
  assign status_w[`EAC_ST_CV]      = regulation_mode_status;
  assign status_w[`EAC_ST_PGOOD]   = power_good;
  assign status_w[`EAC_ST_EN_PIN]  = en_s;
  assign status_w[`EAC_ST_SO_PIN]  = so_s;
  assign status_w[`EAC_ST_LS_PIN]  = local_s;
  assign status_w[`EAC_ST_FEWER]   = fewer_digits;

  // Unmapped and key addresses read zero
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (apb_setup && !pwrite) begin
      case (paddr)
        `EAC_OFF_CTRL:   prdata <= {{(32-`EAC_CTRL_W){1'b0}}, ctrl_r};
        `EAC_OFF_STATUS: prdata <= {{(32-`EAC_ST_W){1'b0}}, status_w};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // eac_top

`default_nettype wire

/* File: rtl/eac_regs.vh */
// Register map, field positions and reset values of the external control logic.
// Assumes byte addresses on an APB bus with 32-bit data, one word per register.
`ifndef EAC_REGS_VH
`define EAC_REGS_VH

// ==========================================================================
// Register byte offsets
`define EAC_OFF_CTRL      8'h00
`define EAC_OFF_KEY       8'h04
`define EAC_OFF_STATUS    8'h08
`define EAC_ADDR_W        8

// ==========================================================================
// Control register fields
`define EAC_CTRL_EXT      0
`define EAC_CTRL_DIRECT   1
`define EAC_CTRL_RISE     2
`define EAC_CTRL_RES      3
`define EAC_CTRL_5V       4
`define EAC_CTRL_W        5
`define EAC_CTRL_RST      5'h00

// ==========================================================================
// Key register fields (write-one pulses, read as zero)
`define EAC_KEY_ONOFF     0
`define EAC_KEY_ESC       1

// ==========================================================================
// Status register fields
`define EAC_ST_OUT_ON     0
`define EAC_ST_INHIBIT    1
`define EAC_ST_SHUTOFF    2
`define EAC_ST_ANALOG     3
`define EAC_ST_CV         4
`define EAC_ST_PGOOD      5
`define EAC_ST_EN_PIN     6
`define EAC_ST_SO_PIN     7
`define EAC_ST_LS_PIN     8
`define EAC_ST_FEWER      9
`define EAC_ST_W          10

`endif

/* File: rtl/eac_sync.v */
// Two-stage synchroniser for a group of pin levels.
// Assumes the pins change with no relation to clk_sys.
`timescale 1ns/10ps
`default_nettype none

module eac_sync #(
  parameter W = 3
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  // Pins and synchronised copy
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] pin_sync
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign pin_sync = sync_r;

endmodule // eac_sync

`default_nettype wire

/* File: rtl/eac_edge.v */
// Edge detector comparing each synchronised level with its previous sample.
// Assumes inputs are already in the clk_sys domain.
`timescale 1ns/10ps
`default_nettype none

module eac_edge #(
  parameter W = 3
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  // Level in, edge pulses out
  input  wire [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  reg [W-1:0] prev_r;
  reg [2:0]   arm_r;
  wire        primed = arm_r[2];

  // Previous sample; edges held off until synchroniser and prev carry real pin
  // samples, so the reset zeros never look like a rise of an idle-high pin
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= {W{1'b0}};
      arm_r  <= 3'h0;
    end else begin
      prev_r <= level;
      arm_r  <= {arm_r[1:0], 1'b1};
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_edge
      assign rise[i] = primed & level[i] & ~prev_r[i];
      assign fall[i] = primed & ~level[i] & prev_r[i];
    end
  endgenerate

endmodule // eac_edge

`default_nettype wire

/* File: tb/eac_props.sv */
// Checker on the ports of eac_top, attached by bind.
// Assumes one clock, clk_sys, and the async reset resetn.
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checker
module eac_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Inputs watched
  input wire logic shutoff_pin,
  input wire logic control_source_pin,
  input wire logic cv_regulating,
  input wire logic fault_ovp,
  input wire logic fault_ocp,
  input wire logic fault_otp,
  input wire logic fault_ac_line,
  input wire logic fault_remote,
  // Outputs watched
  input wire logic regulation_mode_status,
  input wire logic control_source_status,
  input wire logic power_good,
  input wire logic output_on,
  input wire logic enable_inhibit_indicator,
  input wire logic shutoff_indicator,
  input wire logic fewer_digits,
  input wire logic setpoint_from_volt,
  input wire logic setpoint_from_res
);
  logic [1:0] up_cnt_r;
  wire        up   = (up_cnt_r == 2'h3);
  wire        flt  = fault_ovp | fault_ocp | fault_otp | fault_ac_line | fault_remote;
  wire        off  = enable_inhibit_indicator | shutoff_indicator | !output_on;
  wire        prog = setpoint_from_volt | setpoint_from_res;

  // Edges since release; the design idles for two
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) up_cnt_r <= 2'h0;
    else if (!up) up_cnt_r <= up_cnt_r + 2'h1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Shut-off pin moved five samples before the indicator rose
  // (two sync stages, edge compare, latch, indicator register)
  sequence s_so_moved;
    $past(shutoff_pin, 4) != $past(shutoff_pin, 5);
  endsequence

  property p_rms; up |-> regulation_mode_status == $past(cv_regulating); endproperty
  property p_pg_flt; up && flt |=> !power_good; endproperty
  property p_pg_ok; up && power_good |-> !$past(flt); endproperty
  property p_pg_off; up && off && $past(off) |-> !power_good; endproperty
  property p_cs; (up && control_source_pin) [*5] |-> control_source_status; endproperty
  property p_dig; up && fewer_digits && $past(fewer_digits) |-> !control_source_status; endproperty
  property p_prog; up && prog && $past(prog) |-> fewer_digits && !(setpoint_from_volt && setpoint_from_res);
  endproperty
  property p_so_out; up && shutoff_indicator |-> !output_on; endproperty
  property p_so_edge; $rose(shutoff_indicator) |-> s_so_moved; endproperty
  property p_inh; up && enable_inhibit_indicator && $past(enable_inhibit_indicator) |-> !output_on; endproperty

  a_rms:
    assert property (p_rms) else $error("cv status wrong");
  a_pg_flt:
    assert property (p_pg_flt) else $error("fault left power good high");
  a_pg_ok:
    assert property (p_pg_ok) else $error("power good during fault");
  a_pg_off:
    assert property (p_pg_off) else $error("power good while off");
  a_cs:
    assert property (p_cs) else $error("local pin not local");
  a_dig:
    assert property (p_dig) else $error("digits without analog");
  a_prog:
    assert property (p_prog) else $error("setpoint source wrong");
  a_so_out:
    assert property (p_so_out) else $error("output on while shut off");
  a_so_edge:
    assert property (p_so_edge) else $error("shut-off without edge");
  a_inh:
    assert property (p_inh) else $error("output on while inhibited");
endmodule // eac_props

bind eac_top eac_props eac_props_inst (
  .clk_sys, .resetn, .shutoff_pin, .control_source_pin, .cv_regulating, .fault_ovp, .fault_ocp,
  .fault_otp, .fault_ac_line, .fault_remote, .regulation_mode_status, .control_source_status,
  .power_good, .output_on, .enable_inhibit_indicator, .shutoff_indicator, .fewer_digits,
  .setpoint_from_volt, .setpoint_from_res
);
`default_nettype wire

/* File: tb/eac_ext_model.sv */
// External controller on the rear connector: drives the pin levels.
// Assumes set_pins is called just after a clk_sys rising edge.
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Connector driver
module eac_ext_model (
  // Clock
  input  wire logic clk_sys,
  // Connector pins
  output var  logic enable_shorted,
  output var  logic shutoff_pin,
  output var  logic control_source_pin
);
  // Pair open, shut-off idle high, control pin open
  initial begin
    enable_shorted = 1'b0;
    shutoff_pin = 1'b1;
    control_source_pin = 1'b1;
  end
  // New levels at the next rising edge
  task set_pins(input logic en, input logic so, input logic cs);
    @(posedge clk_sys);
    enable_shorted <= en;
    shutoff_pin <= so;
    control_source_pin <= cs;
  endtask
endmodule // eac_ext_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for eac_top: APB tasks, key writes, pin changes.
// Assumes eac_top, eac_ext_model and eac_props compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "eac_regs.vh"
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t %s", $time, m); end end
// ==========================================
// Bench top
module testbench;
  logic        clk_sys, resetn, psel, penable, pwrite, cv_regulating, er;
  logic [4:0]  flt;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  int          n_fail, comparisons;
  wire  [31:0] prdata;
  wire         pready, pslverr, enable_shorted, shutoff_pin, control_source_pin, regulation_mode_status;
  wire         control_source_status, power_good, output_on, enable_inhibit_indicator, shutoff_indicator;
  wire         fewer_digits, setpoint_from_volt, setpoint_from_res, program_range_5v;

  eac_top eac_top_inst (
    .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .enable_shorted, .shutoff_pin, .control_source_pin, .cv_regulating, .fault_ovp(flt[0]),
    .fault_ocp(flt[1]), .fault_otp(flt[2]), .fault_ac_line(flt[3]), .fault_remote(flt[4]),
    .regulation_mode_status, .control_source_status, .power_good, .output_on, .enable_inhibit_indicator,
    .shutoff_indicator, .fewer_digits, .setpoint_from_volt, .setpoint_from_res, .program_range_5v
  );
  eac_ext_model eac_ext_model_inst (.clk_sys, .enable_shorted, .shutoff_pin, .control_source_pin);

  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One APB transfer; read data and error into rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_fail++;
        close_out;
      end
      @(posedge clk_sys);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task key(input logic [1:0] k);
    apb(1'b1, `EAC_OFF_KEY, {30'h0, k});
    cyc(4);
  endtask
  task ctl(input logic [4:0] v);
    apb(1'b1, `EAC_OFF_CTRL, {27'h0, v});
    cyc(3);
  endtask
  task pin(input logic e, input logic s, input logic c);
    eac_ext_model_inst.set_pins(e, s, c);
    cyc(6);
  endtask
  task done(input string s);
    $display("test done: %s", s);
  endtask
  task close_out;
    $display("compares %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, flt, cv_regulating} = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    cyc(3);
    `CHK(control_source_status, 1'b1, "cs rst")
    apb(1'b0, `EAC_OFF_CTRL, 32'h0);
    `CHK(rd, 32'h0, "ctrl rst")
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(er, 1'b1, "unmapped")
    done("reset");
    pin(1'b0, 1'b0, 1'b0);
    key(2'b01);
    `CHK(output_on, 1'b1, "free btn")
    `CHK(control_source_status, 1'b1, "pins ignored")
    `CHK(shutoff_indicator, 1'b0, "no so")
    `CHK(power_good, 1'b1, "pg")
    for (int i = 0; i < 5; i++) begin
      flt <= 5'h01 << i;
      cyc(2);
      `CHK(power_good, 1'b0, "fault")
      flt <= 5'h00;
      cyc(2);
      `CHK(power_good, 1'b1, "clear")
    end
    cv_regulating <= 1'b1;
    cyc(2);
    `CHK(regulation_mode_status, 1'b1, "cv")
    cv_regulating <= 1'b0;
    cyc(2);
    `CHK(regulation_mode_status, 1'b0, "cc")
    done("local");
    pin(1'b0, 1'b1, 1'b1);
    ctl(5'h01);
    `CHK(enable_inhibit_indicator, 1'b1, "inh")
    `CHK(output_on, 1'b0, "forced off")
    key(2'b01);
    `CHK(output_on, 1'b0, "btn ignored")
    pin(1'b1, 1'b1, 1'b1);
    `CHK(enable_inhibit_indicator, 1'b1, "inh held")
    key(2'b10);
    `CHK(enable_inhibit_indicator, 1'b0, "inh esc")
    key(2'b01);
    `CHK(output_on, 1'b1, "btn on")
    done("interlock");
    pin(1'b1, 1'b0, 1'b1);
    `CHK(shutoff_indicator, 1'b1, "so fall")
    `CHK(output_on, 1'b0, "so off")
    key(2'b10);
    `CHK(shutoff_indicator, 1'b1, "esc not idle")
    pin(1'b1, 1'b1, 1'b1);
    `CHK(shutoff_indicator, 1'b1, "so latched")
    key(2'b10);
    `CHK(shutoff_indicator, 1'b0, "so esc")
    key(2'b01);
    `CHK(output_on, 1'b1, "so recover")
    ctl(5'h05);
    pin(1'b1, 1'b0, 1'b1);
    cyc(20);
    `CHK(shutoff_indicator, 1'b0, "wrong edge")
    `CHK(output_on, 1'b1, "steady")
    pin(1'b1, 1'b1, 1'b1);
    `CHK(shutoff_indicator, 1'b1, "so rise")
    `CHK(output_on, 1'b0, "so rise off")
    key(2'b10);
    `CHK(shutoff_indicator, 1'b1, "rise not idle")
    pin(1'b1, 1'b0, 1'b1);
    key(2'b10);
    `CHK(shutoff_indicator, 1'b0, "rise esc")
    done("shutoff");
    ctl(5'h00);
    ctl(5'h03);
    `CHK(output_on, 1'b1, "dir on")
    key(2'b01);
    `CHK(output_on, 1'b1, "dir btn")
    pin(1'b0, 1'b1, 1'b1);
    `CHK(output_on, 1'b0, "dir off")
    pin(1'b1, 1'b1, 1'b0);
    `CHK(control_source_status, 1'b0, "analog")
    `CHK(fewer_digits, 1'b1, "digits")
    `CHK(setpoint_from_volt, 1'b1, "volt")
    `CHK(program_range_5v, 1'b0, "10v")
    apb(1'b0, `EAC_OFF_STATUS, 32'h0);
    `CHK(rd[`EAC_ST_ANALOG], 1'b1, "st analog")
    ctl(5'h1B);
    `CHK(setpoint_from_res, 1'b1, "res")
    `CHK(setpoint_from_volt, 1'b0, "not volt")
    `CHK(program_range_5v, 1'b1, "5v")
    pin(1'b1, 1'b1, 1'b1);
    `CHK(control_source_status, 1'b1, "local")
    `CHK(setpoint_from_res, 1'b0, "res off")
    done("direct analog");
    close_out;
  end
endmodule // testbench
`default_nettype wire
